// file: utes_consts.vh
// constants for the uart transmit-empty status block: offsets, field positions, reset values
// assumes byte addressing on a 32-bit AXI4-Lite bus, one aligned word per register
`ifndef UTES_CONSTS_VH
`define UTES_CONSTS_VH

// ----------------------------------------
// register map
// ----------------------------------------
`define UTES_ADDR_W 8
`define UTES_OFF_LINE_STATUS 8'h00
`define UTES_OFF_CONTROL 8'h04
`define UTES_OFF_INT_STATUS 8'h08
`define UTES_OFF_INT_MASK 8'h0C

// ----------------------------------------
// fields
// ----------------------------------------
`define UTES_LS_HOLD_EMPTY 5
`define UTES_LS_ALL_EMPTY 6
`define UTES_CTL_FIFO_MODE 0
`define UTES_CTL_HOLD_IE 1
`define UTES_EV_HOLD_EMPTY 0
`define UTES_EV_ALL_EMPTY 1
`define UTES_EV_W 2

// ----------------------------------------
// reset values and bus answers
// ----------------------------------------
`define UTES_FLAG_RST 1'h1
`define UTES_CTL_RST 2'h0
`define UTES_EV_RST 2'h0
`define UTES_RESP_OKAY 2'h0
`define UTES_RESP_SLVERR 2'h2

`endif

// file: utes_occupancy.v
// tracks what the transmit path holds and derives the two empty flags
// assumes one-cycle pulses from the uart core, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
`include "utes_consts.vh"

module utes_occupancy (
    input wire clk,
    input wire rst_n,
    input wire hold_load,
    input wire shift_load,
    input wire shift_done,
    input wire fifo_mode,
    input wire fifo_empty,
    output reg holding_empty_flag,
    output reg all_empty_flag
);

reg hold_full;
reg shift_full;
wire next_hold_full;
wire next_shift_full;
wire next_holding_empty;
wire next_all_empty;

// a load in the same cycle as the move keeps the holding register full
assign next_hold_full = hold_load ? 1'b1 : (shift_load ? 1'b0 : hold_full);
assign next_shift_full = shift_load ? 1'b1 : (shift_done ? 1'b0 : shift_full);
// fifo level lags the load by a cycle, so the load itself masks it
assign next_holding_empty = fifo_mode ? (fifo_empty && !hold_load)
                                      : !next_hold_full;
assign next_all_empty = next_holding_empty && !next_hold_full
                        && !next_shift_full;

always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
        hold_full <= 1'b0;
        shift_full <= 1'b0;
        holding_empty_flag <= `UTES_FLAG_RST;
        all_empty_flag <= `UTES_FLAG_RST;
    end else begin
        hold_full <= next_hold_full;
        shift_full <= next_shift_full;
        holding_empty_flag <= next_holding_empty;
        all_empty_flag <= next_all_empty;
    end
end

endmodule
`default_nettype wire

// file: utes_top.v
// uart transmit-empty status: line status flags, interrupt logic, AXI4-Lite slave
// assumes the uart core gives one-cycle load/move/done pulses and a fifo-empty level
`timescale 1ns/1ps
`default_nettype none
`include "utes_consts.vh"

module utes_top (
    input wire core_clk,
    input wire rstn,
    // AXI4-Lite slave
    input wire [`UTES_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`UTES_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // uart transmit path
    input wire tx_hold_load,
    input wire tx_shift_load,
    input wire tx_shift_done,
    input wire tx_fifo_empty,
    output wire irq
);

// ----------------------------------------
// reset release
// ----------------------------------------
reg rst_q1;
reg rst_q2;
wire rst_n;

always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
        rst_q1 <= 1'b0;
        rst_q2 <= 1'b0;
    end else begin
        rst_q1 <= 1'b1;
        rst_q2 <= rst_q1;
    end
end
assign rst_n = rst_q2;

// ----------------------------------------
// flag core
// ----------------------------------------
reg [1:0] control;
wire tx_holding_empty_flag;
wire tx_all_empty_flag;

utes_occupancy utes_occupancy_i (
    .clk(core_clk),
    .rst_n(rst_n),
    .hold_load(tx_hold_load),
    .shift_load(tx_shift_load),
    .shift_done(tx_shift_done),
    .fifo_mode(control[`UTES_CTL_FIFO_MODE]),
    .fifo_empty(tx_fifo_empty),
    .holding_empty_flag(tx_holding_empty_flag),
    .all_empty_flag(tx_all_empty_flag)
);

function [31:0] line_status_word;
    input hold_empty;
    input all_empty;
    begin
        line_status_word = 32'h0;
        line_status_word[`UTES_LS_HOLD_EMPTY] = hold_empty;
        line_status_word[`UTES_LS_ALL_EMPTY] = all_empty;
    end
endfunction

// ----------------------------------------
// write channel
// ----------------------------------------
reg aw_got;
reg w_got;
reg [`UTES_ADDR_W-1:0] aw_addr;
reg [31:0] w_data;
reg w_lane0;
wire aw_fire;
wire w_fire;
wire wr_do;
wire [`UTES_ADDR_W-1:0] wr_addr;
wire [31:0] wr_data;
wire wr_lane0;

assign s_axi_awready = !aw_got && !s_axi_bvalid;
assign s_axi_wready = !w_got && !s_axi_bvalid;
assign aw_fire = s_axi_awvalid && s_axi_awready;
assign w_fire = s_axi_wvalid && s_axi_wready;
// write completes once both halves are present, in either order
assign wr_do = (aw_got || aw_fire) && (w_got || w_fire) && !s_axi_bvalid;
assign wr_addr = aw_got ? aw_addr : s_axi_awaddr;
assign wr_data = w_got ? w_data : s_axi_wdata;
assign wr_lane0 = w_got ? w_lane0 : s_axi_wstrb[0];

function is_mapped;
    input [`UTES_ADDR_W-1:0] a;
    begin
        is_mapped = (a == `UTES_OFF_LINE_STATUS) || (a == `UTES_OFF_CONTROL)
                    || (a == `UTES_OFF_INT_STATUS) || (a == `UTES_OFF_INT_MASK);
    end
endfunction

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        aw_got <= 1'b0;
        w_got <= 1'b0;
        aw_addr <= {`UTES_ADDR_W{1'b0}};
        w_data <= 32'h0;
        w_lane0 <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= `UTES_RESP_OKAY;
    end else begin
        if (wr_do) begin
            aw_got <= 1'b0;
            w_got <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= is_mapped(wr_addr) ? `UTES_RESP_OKAY : `UTES_RESP_SLVERR;
        end else begin
            if (aw_fire) begin
                aw_got <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (w_fire) begin
                w_got <= 1'b1;
                w_data <= s_axi_wdata;
                w_lane0 <= s_axi_wstrb[0];
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
end

// ----------------------------------------
// control, event status and mask
// ----------------------------------------
reg [`UTES_EV_W-1:0] int_status;
reg [`UTES_EV_W-1:0] int_mask;
reg prev_hold_empty;
reg prev_all_empty;
wire [`UTES_EV_W-1:0] ev_set;
wire [`UTES_EV_W-1:0] ev_clr;
wire ctl_wr;
wire mask_wr;
wire stat_wr;

assign ev_set[`UTES_EV_HOLD_EMPTY] = tx_holding_empty_flag && !prev_hold_empty;
assign ev_set[`UTES_EV_ALL_EMPTY] = tx_all_empty_flag && !prev_all_empty;
assign ctl_wr = wr_do && wr_lane0 && (wr_addr == `UTES_OFF_CONTROL);
assign mask_wr = wr_do && wr_lane0 && (wr_addr == `UTES_OFF_INT_MASK);
assign stat_wr = wr_do && wr_lane0 && (wr_addr == `UTES_OFF_INT_STATUS);
assign ev_clr = stat_wr ? wr_data[`UTES_EV_W-1:0] : {`UTES_EV_W{1'b0}};

// line status has no write path at all; such writes answer OKAY and do nothing
always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        control <= `UTES_CTL_RST;
        int_mask <= `UTES_EV_RST;
        int_status <= `UTES_EV_RST;
        prev_hold_empty <= `UTES_FLAG_RST;
        prev_all_empty <= `UTES_FLAG_RST;
    end else begin
        prev_hold_empty <= tx_holding_empty_flag;
        prev_all_empty <= tx_all_empty_flag;
        if (ctl_wr) begin
            control <= wr_data[1:0];
        end
        if (mask_wr) begin
            int_mask <= wr_data[`UTES_EV_W-1:0];
        end
        // set wins over a same-cycle write-one clear
        int_status <= (int_status & ~ev_clr) | ev_set;
    end
end

// holding-empty request stands as a level, independent of the sticky events
assign irq = (tx_holding_empty_flag && control[`UTES_CTL_HOLD_IE])
             || |(int_status & int_mask);

// ----------------------------------------
// read channel
// ----------------------------------------
reg [31:0] next_rdata;
reg [1:0] next_rresp;
wire ar_fire;

assign s_axi_arready = !s_axi_rvalid;
assign ar_fire = s_axi_arvalid && s_axi_arready;

always @* begin
    next_rdata = 32'h0;
    next_rresp = `UTES_RESP_OKAY;
    case (s_axi_araddr)
        `UTES_OFF_LINE_STATUS: begin
            next_rdata = line_status_word(tx_holding_empty_flag,
                                          tx_all_empty_flag);
        end
        `UTES_OFF_CONTROL: begin
            next_rdata[1:0] = control;
        end
        `UTES_OFF_INT_STATUS: begin
            next_rdata[`UTES_EV_W-1:0] = int_status;
        end
        `UTES_OFF_INT_MASK: begin
            next_rdata[`UTES_EV_W-1:0] = int_mask;
        end
        default: begin
            next_rresp = `UTES_RESP_SLVERR;
        end
    endcase
end

always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0;
        s_axi_rresp <= `UTES_RESP_OKAY;
    end else begin
        if (ar_fire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= next_rdata;
            s_axi_rresp <= next_rresp;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

endmodule
`default_nettype wire

// file: utes_top_sva.sv
// port checker for utes_top
// assumes a bind from the bench; one clock, active-low rstn
`timescale 1ns/1ps
`default_nettype none
`include "utes_consts.vh"
module utes_chk (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [`UTES_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_hold_load,
    input wire logic irq
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);
    a_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write answer late");
    a_bresp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("bvalid held");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_rresp_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("rvalid held");
    a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during answer");
    // a loaded character cannot leave the path within two edges
    a_full_clear: assert property (s_axi_arvalid && s_axi_arready &&
        s_axi_araddr == 8'h00 && ($past(tx_hold_load) || $past(tx_hold_load, 2))
        |=> !s_axi_rdata[6]) else $error("all-empty set while loaded");
    a_unmapped_rd: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h0C
        |=> s_axi_rresp == `UTES_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
    c_irq: cover property ($rose(irq));
    c_write: cover property (s_axi_bvalid && s_axi_bready);
    c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule
`default_nettype wire

// file: tb_top.sv
// bench for utes_top: bus and pulse tasks, one task per scenario
// assumes utes_top.v and utes_consts.vh alongside
`timescale 1ns/1ps
`default_nettype none
`include "utes_consts.vh"
module tb_top;
    reg core_clk = 1'h0, rstn = 1'h0;
    reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    reg [31:0] s_axi_wdata = 32'h0, q;
    reg [3:0] s_axi_wstrb = 4'hF;
    reg s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    reg s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, tx_fifo_empty = 1'h1;
    reg tx_hold_load = 1'h0, tx_shift_load = 1'h0, tx_shift_done = 1'h0;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata;
    reg [1:0] r;
    integer err_total = 0, n_checks = 0;
    utes_top utes_top_i (
        .core_clk(core_clk),
        .rstn(rstn),
        .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready),
        .tx_hold_load(tx_hold_load),
        .tx_shift_load(tx_shift_load),
        .tx_shift_done(tx_shift_done),
        .tx_fifo_empty(tx_fifo_empty),
        .irq(irq)
    );
    initial forever #10 core_clk = ~core_clk;
    task results;
        begin
            $display("checks %0d mismatches %0d", n_checks, err_total);
            if (err_total == 0 && n_checks > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task chk(input [31:0] s, input [31:0] e);
        begin
            n_checks = n_checks + 1;
            if (s !== e) begin
                err_total = err_total + 1;
                $display("[ERR] %0t seen %h exp %h", $time, s, e);
            end
        end
    endtask
    // readies are sampled at the falling edge, where they are settled
    task xf(input we, input [7:0] a, input [31:0] d);
        integer i;
        reg [2:0] p, t;
        begin
            @(posedge core_clk);
            s_axi_awaddr <= a;
            s_axi_araddr <= a;
            s_axi_wdata <= d;
            s_axi_awvalid <= we;
            s_axi_wvalid <= we;
            s_axi_bready <= we;
            s_axi_arvalid <= !we;
            s_axi_rready <= !we;
            p = we ? 3'h7 : 3'h5;
            for (i = 0; i < 40 && p != 3'h0; i = i + 1) begin
                @(negedge core_clk);
                t = p & (we ? {s_axi_awready, s_axi_wready, s_axi_bvalid}
                    : {s_axi_arready, 1'h0, s_axi_rvalid});
                q = s_axi_rdata;
                r = we ? s_axi_bresp : s_axi_rresp;
                @(posedge core_clk);
                p = p & ~t;
                s_axi_awvalid <= s_axi_awvalid && !t[2];
                s_axi_arvalid <= s_axi_arvalid && !t[2];
                s_axi_wvalid <= s_axi_wvalid && !t[1];
                s_axi_bready <= s_axi_bready && !t[0];
                s_axi_rready <= s_axi_rready && !t[0];
            end
            if (p != 3'h0) begin
                err_total = err_total + 1;
                $display("[ERR] %0t timeout %h %h", $time, p, 3'h0);
                results;
            end
        end
    endtask
    task tx(input [2:0] m);
        begin
            @(posedge core_clk);
            {tx_hold_load, tx_shift_load, tx_shift_done} <= m;
            @(posedge core_clk);
            {tx_hold_load, tx_shift_load, tx_shift_done} <= 3'h0;
        end
    endtask
    task ls(input [31:0] e);
        begin
            xf(1'h0, 8'h00, 32'h0);
            chk(r, `UTES_RESP_OKAY);
            chk(q, e);
        end
    endtask
    task ck(input e);
        begin
            @(negedge core_clk);
            chk(irq, e);
        end
    endtask
    task t_reset;
        begin
            ls(32'h60);
            xf(1'h0, 8'h40, 32'h0);
            chk(r, `UTES_RESP_SLVERR);
            chk(q, 32'h0);
            $display("reset test done");
        end
    endtask
    task t_path;
        begin
            tx(3'h4);
            ls(32'h00);
            tx(3'h2);
            ls(32'h20);
            tx(3'h1);
            ls(32'h60);
            tx(3'h4);
            tx(3'h6);
            xf(1'h1, 8'h00, 32'hFF);
            chk(r, `UTES_RESP_OKAY);
            ls(32'h00);
            tx(3'h3);
            ls(32'h20);
            tx(3'h1);
            xf(1'h0, 8'h08, 32'h0);
            chk(q, 32'h3);
            xf(1'h1, 8'h08, 32'h3);
            $display("path test done");
        end
    endtask
    task t_irq;
        begin
            xf(1'h1, 8'h04, 32'h2);
            ck(1'h1);
            tx(3'h4);
            ck(1'h0);
            tx(3'h2);
            ck(1'h1);
            xf(1'h1, 8'h04, 32'h0);
            xf(1'h1, 8'h0C, 32'h1);
            ck(1'h1);
            xf(1'h1, 8'h08, 32'h1);
            tx(3'h1);
            ck(1'h0);
            xf(1'h1, 8'h0C, 32'h0);
            xf(1'h1, 8'h08, 32'h3);
            $display("irq test done");
        end
    endtask
    task t_fifo;
        begin
            xf(1'h1, 8'h04, 32'h1);
            tx_fifo_empty <= 1'h0;
            tx(3'h4);
            ls(32'h00);
            tx(3'h2);
            ls(32'h00);
            @(posedge core_clk);
            tx_fifo_empty <= 1'h1;
            ls(32'h20);
            tx(3'h1);
            ls(32'h60);
            $display("fifo test done");
        end
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rstn <= 1'h1;
        repeat (3) @(posedge core_clk);
        t_reset;
        t_path;
        t_irq;
        t_fifo;
        results;
    end
endmodule
bind utes_top utes_chk utes_chk_i (
    .core_clk(core_clk),
    .rstn(rstn),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .tx_hold_load(tx_hold_load),
    .irq(irq)
);
`default_nettype wire
